// ==== core/tsc_defs.vh ====
/*
  offsets, field positions, reset values and timing counts for the
  thermal sensor control block.
  assumes: included by bare name from the core design files.
*/
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH

// apb byte offsets
`define TSC_OFS_CONTROL 12'h000
`define TSC_OFS_TRIM 12'h004
`define TSC_OFS_IRQ_STATUS 12'h008
`define TSC_OFS_IRQ_MASK 12'h00c

// thermal_control fields
`define TSC_CTL_TEST_HI 7
`define TSC_CTL_TEST_LO 6
`define TSC_CTL_SOURCE_SELECT 5
`define TSC_CTL_ROUTE_ENABLE 4
`define TSC_CTL_SENSOR_ENABLE 3
`define TSC_CTL_DETECT_STATUS 2
`define TSC_CTL_IRQ_ENABLE 1
`define TSC_CTL_CHANGE_FLAG 0

// thermal_trim fields
`define TSC_TRIM_OFFSET_ENABLE 7
`define TSC_TRIM_LEVEL_HI 3
`define TSC_TRIM_LEVEL_LO 0

// reset values
`define TSC_CONTROL_RESET 8'h00
`define TSC_TRIM_RESET 8'h0f
`define TSC_MASK_RESET 1'b0

// typical alarm shift per trim step, degrees celsius
`define TSC_STEP_DEGREES 8'h05

// reset-phase load wait, in ns, and its cycle count at 25 ns
`define TSC_LOAD_TIME_NS 100
`define TSC_CLK_PERIOD_NS 25
`define TSC_LOAD_CYCLES ((`TSC_LOAD_TIME_NS + `TSC_CLK_PERIOD_NS - 1) / `TSC_CLK_PERIOD_NS)

`endif

// ==== core/tsc_sync.v ====
/*
  two-flop synchroniser for a single level.
  assumes: input is asynchronous to clk; srst synchronous active high.
*/
`timescale 1ns/10ps
module tsc_sync
(
  input wire clk,
  input wire srst,
  input wire asyncIn,
  output wire syncOut
);

  reg stage1_r;
  reg stage2_r;

  // first stage is read only by the second
  always @(posedge clk)
  begin
    if (srst)
    begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end
    else
    begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end

  assign syncOut = stage2_r;

endmodule

// ==== core/tsc_trim_offset.v ====
/*
  trim offset arithmetic: turns offset enable and trim level into the
  alarm shift in degrees, same for assert and deassert levels.
  assumes: inputs from flip-flops on the same clock.
*/
`timescale 1ns/10ps
`include "tsc_defs.vh"
module tsc_trim_offset
(
  input wire clk,
  input wire srst,
  input wire offsetEnable,
  input wire [3:0] trimLevel,
  output reg [7:0] alarmShift,
  output reg [3:0] offsetCode
);

  // binary weighted: bit n counts 2**n unit steps
  function [7:0] shift_of;
    input [3:0] lvl;
    begin
      shift_of = {4'h0, lvl} * `TSC_STEP_DEGREES;
    end
  endfunction

  // offset only; the slope input of the sensor is never touched
  always @(posedge clk)
  begin
    if (srst)
    begin
      alarmShift <= 8'h00;
      offsetCode <= 4'h0;
    end
    else if (offsetEnable)
    begin
      alarmShift <= shift_of(trimLevel);
      offsetCode <= trimLevel;
    end
    else
    begin
      alarmShift <= 8'h00;
      offsetCode <= 4'h0;
    end
  end

endmodule

// ==== core/tsc_thermal_sensor_control.v ====
/*
  thermal sensor control: apb register file, analog control outputs,
  over-temperature detect status, change flag and interrupt.
  assumes: comparator levels and regulator mode arrive asynchronously;
  factory trim word is stable while srst is high and just after.
*/
`timescale 1ns/10ps
`include "tsc_defs.vh"

// Overview of operation
// - test bits writable only in special mode
// - bit5 picks sensor or bandgap voltage
// - bit4 connects chosen voltage to converter
// - bit3 enables the temperature sensor
// - status high above assert in full mode
// - interrupt enable gates change flag request
// - flag set on every status transition
// - flag cleared by writing one or reset
// - reduced power entry sets change flag if status high, never clears it
// - bits 2..0 never alter converter voltage
// - trim loaded from factory word at reset
// - trim bit7 enables the sensor offset
// - trim level binary weighted downwards
// - same shift on assert and deassert
// - trim changes offset, never the slope
// - sensor disabled in reduced power mode
module tsc_thermal_sensor_control
(
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire specialMode,
  input wire fullPerformanceMode,
  input wire reducedPowerMode,
  input wire alarmAssertCross,
  input wire alarmDeassertCross,
  input wire [7:0] factoryTrim,
  output reg sensorPowerOn,
  output reg routeSensorVoltage,
  output reg routeBandgapVoltage,
  output reg offsetOn,
  output wire [3:0] offsetCode,
  output wire [7:0] alarmShift,
  output wire overtempInterrupt
);

  localparam ST_LOAD = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_r;
  reg [2:0] loadCnt_r;
  reg [1:0] testBits_r;
  reg sourceSelect_r;
  reg routeEnable_r;
  reg sensorEnable_r;
  reg detectStatus_r;
  reg irqEnable_r;
  reg changeFlag_r;
  reg offsetTrimEnable_r;
  reg [3:0] trimLevel_r;
  reg irqMask_r;
  reg detectStatus_nxt;

  wire fpmSync;
  wire rpmSync;
  wire assertSync;
  wire deassertSync;
  wire specialSync;
  wire wrEn;
  wire rdEn;
  wire mapped;
  wire lane0;
  wire sensorActive;
  wire [7:0] controlRead;
  wire [7:0] trimRead;
  wire [7:0] trimResetWord;

  // trim reset image, split into its fields below
  assign trimResetWord = `TSC_TRIM_RESET;

  // level inputs from the analog side and mode pins
  tsc_sync uSyncFpm
  (
    .clk(clk),
    .srst(srst),
    .asyncIn(fullPerformanceMode),
    .syncOut(fpmSync)
  );
  tsc_sync uSyncRpm
  (
    .clk(clk),
    .srst(srst),
    .asyncIn(reducedPowerMode),
    .syncOut(rpmSync)
  );
  tsc_sync uSyncAssert
  (
    .clk(clk),
    .srst(srst),
    .asyncIn(alarmAssertCross),
    .syncOut(assertSync)
  );
  tsc_sync uSyncDeassert
  (
    .clk(clk),
    .srst(srst),
    .asyncIn(alarmDeassertCross),
    .syncOut(deassertSync)
  );
  tsc_sync uSyncSpecial
  (
    .clk(clk),
    .srst(srst),
    .asyncIn(specialMode),
    .syncOut(specialSync)
  );

  // trim arithmetic for the analog offset ladder
  tsc_trim_offset uTrim
  (
    .clk(clk),
    .srst(srst),
    .offsetEnable(offsetTrimEnable_r),
    .trimLevel(trimLevel_r),
    .alarmShift(alarmShift),
    .offsetCode(offsetCode)
  );

  // apb decode: zero wait state, unmapped offsets flag an error
  assign pready = 1'b1;
  assign mapped = (paddr == `TSC_OFS_CONTROL) ||
                  (paddr == `TSC_OFS_TRIM) ||
                  (paddr == `TSC_OFS_IRQ_STATUS) ||
                  (paddr == `TSC_OFS_IRQ_MASK);
  assign pslverr = psel & penable & ~mapped;
  assign wrEn = psel & penable & pwrite & (state_r == ST_RUN);
  assign rdEn = psel & penable & ~pwrite;
  assign lane0 = pstrb[0];

  // sensor runs only when enabled and not in stop mode
  assign sensorActive = sensorEnable_r & ~rpmSync;

  // read images
  assign controlRead = {testBits_r, sourceSelect_r, routeEnable_r,
                        sensorEnable_r, detectStatus_r, irqEnable_r,
                        changeFlag_r};
  assign trimRead = {offsetTrimEnable_r, 3'b000, trimLevel_r};

  // detect status with hysteresis, forced low outside full mode
  always @*
  begin
    detectStatus_nxt = detectStatus_r;
    if (!fpmSync || rpmSync || !sensorActive)
      detectStatus_nxt = 1'b0;
    else if (assertSync)
      detectStatus_nxt = 1'b1;
    else if (!deassertSync)
      detectStatus_nxt = 1'b0;
  end

  // reset phase: wait, then take the factory trim word
  always @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ST_LOAD;
      loadCnt_r <= 3'h0;
    end
    else
    begin
      case (state_r)
        ST_LOAD:
        begin
          if (loadCnt_r == (`TSC_LOAD_CYCLES - 1))
            state_r <= ST_RUN;
          else
            loadCnt_r <= loadCnt_r + 3'h1;
        end
        default:
          state_r <= ST_RUN;
      endcase
    end
  end

  // control register and status
  always @(posedge clk)
  begin
    if (srst)
    begin
      testBits_r <= 2'b00;
      sourceSelect_r <= 1'b0;
      routeEnable_r <= 1'b0;
      sensorEnable_r <= 1'b0;
      irqEnable_r <= 1'b0;
      detectStatus_r <= 1'b0;
      changeFlag_r <= 1'b0;
      irqMask_r <= `TSC_MASK_RESET;
    end
    else
    begin
      // status is hardware driven only
      detectStatus_r <= detectStatus_nxt;
      if (wrEn && lane0 && paddr == `TSC_OFS_CONTROL)
      begin
        if (specialSync)
          testBits_r <= pwdata[`TSC_CTL_TEST_HI:`TSC_CTL_TEST_LO];
        sourceSelect_r <= pwdata[`TSC_CTL_SOURCE_SELECT];
        routeEnable_r <= pwdata[`TSC_CTL_ROUTE_ENABLE];
        sensorEnable_r <= pwdata[`TSC_CTL_SENSOR_ENABLE];
        irqEnable_r <= pwdata[`TSC_CTL_IRQ_ENABLE];
      end
      if (wrEn && lane0 && paddr == `TSC_OFS_IRQ_MASK)
        irqMask_r <= pwdata[0];
      // a transition wins over a simultaneous clear
      if (detectStatus_nxt != detectStatus_r)
        changeFlag_r <= 1'b1;
      else if (wrEn && lane0 &&
               (paddr == `TSC_OFS_CONTROL ||
                paddr == `TSC_OFS_IRQ_STATUS) &&
               pwdata[`TSC_CTL_CHANGE_FLAG])
        changeFlag_r <= 1'b0;
    end
  end

  // trim register: factory load, then software owned
  always @(posedge clk)
  begin
    if (srst)
    begin
      offsetTrimEnable_r <= trimResetWord[`TSC_TRIM_OFFSET_ENABLE];
      trimLevel_r <= trimResetWord[`TSC_TRIM_LEVEL_HI:`TSC_TRIM_LEVEL_LO];
    end
    else if (state_r == ST_LOAD)
    begin
      offsetTrimEnable_r <= factoryTrim[`TSC_TRIM_OFFSET_ENABLE];
      trimLevel_r <= factoryTrim[`TSC_TRIM_LEVEL_HI:`TSC_TRIM_LEVEL_LO];
    end
    else if (wrEn && lane0 && paddr == `TSC_OFS_TRIM)
    begin
      offsetTrimEnable_r <= pwdata[`TSC_TRIM_OFFSET_ENABLE];
      trimLevel_r <= pwdata[`TSC_TRIM_LEVEL_HI:`TSC_TRIM_LEVEL_LO];
    end
  end

  // analog control outputs; status, irq bits never feed the routing
  always @(posedge clk)
  begin
    if (srst)
    begin
      sensorPowerOn <= 1'b0;
      routeSensorVoltage <= 1'b0;
      routeBandgapVoltage <= 1'b0;
      offsetOn <= 1'b0;
    end
    else
    begin
      sensorPowerOn <= sensorActive;
      routeSensorVoltage <= routeEnable_r & ~sourceSelect_r;
      routeBandgapVoltage <= routeEnable_r & sourceSelect_r;
      offsetOn <= offsetTrimEnable_r & sensorActive;
    end
  end

  // read data registered on the access phase
  always @(posedge clk)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (rdEn)
    begin
      if (paddr == `TSC_OFS_CONTROL)
        prdata <= {24'h00_0000, controlRead};
      else if (paddr == `TSC_OFS_TRIM)
        prdata <= {24'h00_0000, trimRead};
      else if (paddr == `TSC_OFS_IRQ_STATUS)
        prdata <= {31'h0000_0000, changeFlag_r};
      else if (paddr == `TSC_OFS_IRQ_MASK)
        prdata <= {31'h0000_0000, irqMask_r};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // request while flag set, enabled and not masked off
  assign overtempInterrupt = changeFlag_r & irqEnable_r & irqMask_r;

endmodule

// ==== dv/tsc_monitor.sv ====
/* port checker for the thermal sensor control block.
   assumes: bound to tsc_thermal_sensor_control, one clock. */
`timescale 1ns/10ps
module tsc_monitor
(
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire reducedPowerMode,
  input wire sensorPowerOn,
  input wire routeSensorVoltage,
  input wire routeBandgapVoltage,
  input wire offsetOn,
  input wire [3:0] offsetCode,
  input wire [7:0] alarmShift,
  input wire overtempInterrupt
);
  // access phase and control write decode
  wire acc = psel && penable;
  wire wrCtl = acc && pwrite && paddr == 12'h000 && pstrb[0];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // bus answer and decode
  ready_now_a: assert property (acc |-> pready)
    else $error("ready missing in access");
  slverr_map_a: assert property (acc |-> pslverr ==
    (paddr > 12'h00c || paddr[1:0] != 2'b00)) else $error("bad slverr");
  // converter routing and sensor power
  route_excl_a: assert property (
    !(routeSensorVoltage && routeBandgapVoltage)) else $error("both routed");
  src_select_a: assert property (wrCtl && pwdata[5:4] == 2'b11
    |=> ##1 routeBandgapVoltage) else $error("bandgap not routed");
  route_off_a: assert property (wrCtl && !pwdata[4]
    |=> ##1 !routeSensorVoltage && !routeBandgapVoltage)
    else $error("route stayed on");
  sensor_off_a: assert property (wrCtl && !pwdata[3]
    |=> ##1 !sensorPowerOn) else $error("sensor stayed on");
  // interrupt gating and stickiness, sensor power in stop, trim shift scale
  irq_off_a: assert property (wrCtl && !pwdata[1]
    |=> !overtempInterrupt) else $error("irq while disabled");
  irq_hold_a: assert property (overtempInterrupt && !(acc && pwrite)
    |=> overtempInterrupt) else $error("irq dropped without write");
  stop_power_a: assert property (reducedPowerMode[*5]
    |-> !sensorPowerOn) else $error("sensor on in stop");
  shift_scale_a: assert property (($stable(offsetCode)
    && $stable(offsetOn))[*2] |-> alarmShift ==
    ({4'h0, offsetCode} * 8'h05)) else $error("bad shift");
endmodule

bind tsc_thermal_sensor_control tsc_monitor i_mon
(
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .pslverr, .reducedPowerMode, .sensorPowerOn,
  .routeSensorVoltage, .routeBandgapVoltage, .offsetOn, .offsetCode,
  .alarmShift, .overtempInterrupt
);

// ==== dv/tsc_analog_model.sv ====
/* analog side model: alarm comparators and regulator mode levels.
   assumes: levels are asynchronous to the core clock. */
`timescale 1ns/10ps
module tsc_analog_model
#(
  parameter [7:0] ASSERT_C = 8'h8c,
  parameter [7:0] DEASSERT_C = 8'h82
)
(
  input wire [7:0] dieTemp,
  input wire stopMode,
  input wire sensorPowerOn,
  input wire [7:0] alarmShift,
  output wire fullPerformanceMode,
  output wire reducedPowerMode,
  output wire alarmAssertCross,
  output wire alarmDeassertCross
);
  // regulator is in stop or in full mode
  assign reducedPowerMode = stopMode;
  assign fullPerformanceMode = !stopMode;
  // both levels drop by one shift; silent while unpowered
  assign alarmAssertCross = sensorPowerOn
    && dieTemp > ASSERT_C - alarmShift;
  assign alarmDeassertCross = sensorPowerOn
    && dieTemp > DEASSERT_C - alarmShift;
endmodule

// ==== dv/tsc_testbench.sv ====
/* self-checking bench for the thermal sensor control block.
   assumes: apb master here, analog model on the far side. */
`timescale 1ns/10ps
module testbench;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg specialMode = 1'b0;
  reg stopMode = 1'b0;
  reg [7:0] dieTemp = 8'h19;
  wire pready, pslverr, full_performance_mode, reduced_power_mode, aCross, dCross, sensorPowerOn;
  wire routeSensorVoltage, routeBandgapVoltage, offsetOn;
  wire overtempInterrupt;
  wire [3:0] offsetCode;
  wire [7:0] alarmShift;
  wire [31:0] prdata;
  reg [31:0] rdata;
  reg err;
  integer mismatches = 0;
  integer cmp_count = 0;
  // free running clock
  always #12.5 clk = ~clk;
  tsc_thermal_sensor_control i_dut
  (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .specialMode(specialMode), .fullPerformanceMode(full_performance_mode),
    .reducedPowerMode(reduced_power_mode), .alarmAssertCross(aCross),
    .alarmDeassertCross(dCross), .factoryTrim(8'h0f),
    .sensorPowerOn(sensorPowerOn), .offsetOn(offsetOn),
    .routeSensorVoltage(routeSensorVoltage),
    .routeBandgapVoltage(routeBandgapVoltage), .offsetCode(offsetCode),
    .alarmShift(alarmShift), .overtempInterrupt(overtempInterrupt)
  );
  tsc_analog_model i_ana
  (
    .dieTemp(dieTemp), .stopMode(stopMode),
    .sensorPowerOn(sensorPowerOn), .alarmShift(alarmShift),
    .fullPerformanceMode(full_performance_mode), .reducedPowerMode(reduced_power_mode),
    .alarmAssertCross(aCross), .alarmDeassertCross(dCross)
  );
  task chk(input [79:0] name, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("ERROR %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  // one apb transfer; read data settles one cycle after access
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      #1 rdata = prdata;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [79:0] name, input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(name, rdata, exp);
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task t_reset;
    begin
      rdc("trim", 12'h004, 32'h0f);
      rdc("ctl", 12'h000, 32'h00);
      rdc("mask", 12'h00c, 32'h00);
      rdc("unmapped", 12'h010, 32'h00);
      chk("slverr", err, 32'h1);
      $display("reset test done");
    end
  endtask
  task t_ctl;
    begin
      wr(12'h000, 32'hc4);
      rdc("locked", 12'h000, 32'h00);
      specialMode <= 1'b1;
      repeat (3) @(posedge clk);
      wr(12'h000, 32'hc0);
      rdc("testbits", 12'h000, 32'hc0);
      wr(12'h000, 32'h00);
      specialMode <= 1'b0;
      wr(12'h000, 32'h18);
      rdc("monitor", 12'h000, 32'h18);
      chk("power", sensorPowerOn, 32'h1);
      chk("vsensor", routeSensorVoltage, 32'h1);
      wr(12'h000, 32'h3f);
      chk("vbandgap", {routeBandgapVoltage, routeSensorVoltage}, 32'h2);
      $display("control test done");
    end
  endtask
  task t_irq;
    begin
      wr(12'h000, 32'h1a);
      dieTemp <= 8'h96;
      repeat (8) @(posedge clk);
      rdc("raise", 12'h000, 32'h1f);
      chk("masked", overtempInterrupt, 32'h0);
      wr(12'h00c, 32'h01);
      chk("irq", overtempInterrupt, 32'h1);
      wr(12'h000, 32'h1a);
      rdc("keep", 12'h000, 32'h1f);
      wr(12'h000, 32'h1b);
      rdc("clear", 12'h000, 32'h1e);
      chk("irqoff", overtempInterrupt, 32'h0);
      dieTemp <= 8'h87;
      repeat (8) @(posedge clk);
      rdc("hyst", 12'h000, 32'h1e);
      stopMode <= 1'b1;
      repeat (8) @(posedge clk);
      rdc("stop", 12'h000, 32'h1b);
      chk("stoppower", sensorPowerOn, 32'h0);
      wr(12'h008, 32'h01);
      rdc("alias", 12'h000, 32'h1a);
      stopMode <= 1'b0;
      dieTemp <= 8'h19;
      $display("interrupt test done");
    end
  endtask
  task t_trim;
    begin
      wr(12'h004, 32'h8f);
      rdc("trim", 12'h004, 32'h8f);
      chk("shift", {offsetOn, offsetCode, alarmShift}, 32'h1f4b);
      wr(12'h004, 32'h02);
      chk("noshift", {offsetOn, alarmShift}, 32'h0);
      $display("trim test done");
    end
  endtask
  // watchdog against a hang
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    end_sim;
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_ctl;
    t_irq;
    t_trim;
    end_sim;
  end
endmodule
